// file: logic/ccsp_regs.vh
// Constants for the codec control and serial port block
`ifndef CCSP_REGS_VH
`define CCSP_REGS_VH
// Device address on the three-wire port (arbitrary value)
`define CCSP_OWN_ADDR 6'h2A
// Transfer types, address byte bits 1:0
`define CCSP_TYPE_DATA 2'h0
`define CCSP_TYPE_STATUS 2'h2
// Register selectors, data byte bits 7:6
`define CCSP_SEL_ATTEN 2'h0
`define CCSP_SEL_BOOST 2'h1
`define CCSP_SEL_EMPH 2'h2
`define CCSP_SEL_POWER 2'h3
// Reset values of the write-only registers
`define CCSP_CFG_RST 6'h00
`define CCSP_ATTEN_RST 6'h00
`define CCSP_BOOST_RST 6'h00
`define CCSP_EMPH_RST 6'h00
`define CCSP_POWER_RST 6'h03
// Mode select codes {ctrl_sel_b, ctrl_sel_a}
`define CCSP_MODE_SERIAL 2'h0
`define CCSP_MODE_TEST 2'h1
`define CCSP_MODE_STATIC 2'h3
// Three-level pin codes
`define CCSP_LVL_LOW 2'h0
`define CCSP_LVL_MID 2'h1
`define CCSP_LVL_HIGH 2'h2
// Sample periods and bits per port byte
`define CCSP_MUTE_FS_OFF 1024
`define CCSP_MUTE_FS_ON 12288
`define CCSP_OVL_FS 512
`define CCSP_BITS_PER_BYTE 8
`endif

// file: logic/ccsp_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module ccsp_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: logic/ccsp_top.v
// Codec control: mode pins, static decode, three-wire port, output hold
// Function
// - Hold ADC serial output low 1024 or 12288 samples after start.
// - Both select pins high give static mode; b low, a high test.
// - Both select pins low give serial control; pins become port pins.
// - Static mode: clock ratio pin low 256x, high 384x.
// - Static mode: emphasis pin low none, mid 44.1k, high mute.
// - Static mode: format pins 00 MSB, 01 I2S, 10 LSB20, 11 LSB16.
// - Static mode: gain pin low power-down, mid 6 dB, high 0 dB.
// - Serial mode: overload flag high 512 samples, retriggered.
// - Serial mode: gain pin low 0 dB, high 6 dB.
// - Bytes arrive least significant bit first; address or data phase.
// - Address bits 7:2 compared with own six-bit address.
// - Address bits 1:0: 00 data, 10 status, others unused.
// - Selection kept until next address; mismatch deselects.
// - Data committed after eighth bit; several bytes allowed.
// - Data bits 7:6 pick register, bits 5:0 its value.
// - Status 00: ratio bits 5:4, format 3:1, offset enable 0.
// - Data selectors: attenuation, boost, emphasis/mute/curve, power.
// - Ratio field 00 512x, 01 384x, 10 256x, 11 unused.
// - Format field decodes I2S, LSB and MSB variants.
// - Offset enable clear disables, set enables high-pass filter.
// - Attenuation 1 dB steps, codes 0,1 are 0 dB, top two silent.
// - Emphasis field 00 none, 01 32k, 10 44.1k, 11 48k.
// - Curve field 00 flat, 01/10 minimum, 11 maximum.
// - Power field upper bit ADC on, lower bit DAC on.
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_regs.vh"
module ccsp_top (
  input wire clk_i,
  input wire rst_i,
  input wire ctrl_sel_a_i,
  input wire ctrl_sel_b_i,
  input wire clk_ratio_pin_or_shift_clock_i,
  input wire [1:0] emph_mute_pin_or_phase_line_i,
  input wire [1:0] gain_pwr_pin_or_serial_line_i,
  input wire fmt_sel_b_or_gain_pin_i,
  input wire fmt_sel_a_i,
  input wire sample_tick_i,
  input wire overload_det_i,
  input wire adc_filter_valid_i,
  input wire adc_data_i,
  output reg fmt_sel_a_or_overload_flag_o,
  output reg adc_serial_out_o,
  output reg [1:0] mode_o,
  output reg [1:0] sysclk_ratio_sel_o,
  output reg [2:0] fmt_o,
  output reg offset_block_en_o,
  output reg [5:0] atten_level_o,
  output reg [3:0] low_boost_level_o,
  output reg [1:0] high_boost_level_o,
  output reg [1:0] emph_sel_o,
  output reg silence_en_o,
  output reg [1:0] curve_o,
  output reg [1:0] converter_power_sel_o,
  output reg gain_6db_o
);
  // Synchronised pins: {shift clk, phase, serial, fmt_b/gain, fmt a, sel a, sel b}
  wire [8:0] pin_s;
  ccsp_sync #(.W(9)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({clk_ratio_pin_or_shift_clock_i, emph_mute_pin_or_phase_line_i,
          gain_pwr_pin_or_serial_line_i, fmt_sel_b_or_gain_pin_i,
          fmt_sel_a_i, ctrl_sel_a_i, ctrl_sel_b_i}),
    .q_o(pin_s)
  );
  wire sclk_s = pin_s[8];
  wire [1:0] emph_lvl_s = pin_s[7:6];
  wire [1:0] gain_lvl_s = pin_s[5:4];
  wire phase_s = pin_s[7];
  wire sdata_s = pin_s[5];
  wire fmt_b_s = pin_s[3];
  wire fmt_a_s = pin_s[2];
  wire [1:0] mode_s = {pin_s[0], pin_s[1]};

  // Serial decoded fields, held across mode changes
  reg [5:0] cfg_reg;
  reg [5:0] atten_reg;
  reg [5:0] boost_reg;
  reg [5:0] emph_reg;
  reg [5:0] power_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg sclk_d_reg;
  reg phase_d_reg;
  reg selected_reg;
  reg [1:0] xfer_type_reg;
  reg [13:0] hold_cnt_reg;
  reg [9:0] ovl_cnt_reg;
  reg pwr_adc_d_reg;

  // Three-level pin: 00 low, 01 mid, 1x high
  function [1:0] lvl3;
    input [1:0] p;
    begin
      if (p[1])
        lvl3 = `CCSP_LVL_HIGH;
      else if (p[0])
        lvl3 = `CCSP_LVL_MID;
      else
        lvl3 = `CCSP_LVL_LOW;
    end
  endfunction

  // Pins are not valid until both synchroniser stages have loaded;
  // without this the reset zeros read as serial mode for two cycles
  reg [1:0] settle_reg;
  wire pins_ok = settle_reg[1];
  always @(posedge clk_i) begin
    if (rst_i)
      settle_reg <= 2'h0;
    else if (!pins_ok)
      settle_reg <= settle_reg + 2'h1;
  end

  wire serial_mode = pins_ok && (mode_s == `CCSP_MODE_SERIAL);
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire [7:0] byte_next = {sdata_s, shift_reg[7:1]};
  wire byte_done = sclk_rise && (bit_cnt_reg == 3'h7);

  // Three-wire port receiver; phase edge restarts byte framing
  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
      phase_d_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      selected_reg <= 1'b0;
      xfer_type_reg <= `CCSP_TYPE_DATA;
      cfg_reg <= `CCSP_CFG_RST;
      atten_reg <= `CCSP_ATTEN_RST;
      boost_reg <= `CCSP_BOOST_RST;
      emph_reg <= `CCSP_EMPH_RST;
      power_reg <= `CCSP_POWER_RST;
    end else begin
      sclk_d_reg <= sclk_s;
      phase_d_reg <= phase_s;
      if (!serial_mode || phase_s != phase_d_reg) begin
        bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
        shift_reg <= byte_next; // LSB first
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done && !phase_s) begin
          // Address phase byte
          selected_reg <= (byte_next[7:2] == `CCSP_OWN_ADDR);
          xfer_type_reg <= byte_next[1:0];
        end else if (byte_done && selected_reg) begin
          // Data phase commit after eighth bit
          if (xfer_type_reg == `CCSP_TYPE_STATUS) begin
            if (byte_next[7:6] == 2'h0)
              cfg_reg <= byte_next[5:0];
          end else if (xfer_type_reg == `CCSP_TYPE_DATA) begin
            case (byte_next[7:6])
              `CCSP_SEL_ATTEN: atten_reg <= byte_next[5:0];
              `CCSP_SEL_BOOST: boost_reg <= byte_next[5:0];
              `CCSP_SEL_EMPH: emph_reg <= byte_next[5:0];
              default: power_reg <= byte_next[5:0];
            endcase
          end
        end
      end
    end
  end

  // Codes that the static pins map onto, in the serial field encodings
  localparam [1:0] RATIO_384 = 2'h1;
  localparam [1:0] RATIO_256 = 2'h2;
  localparam [2:0] FMT_I2S = 3'h0;
  localparam [2:0] FMT_MSB = 3'h4;
  localparam [2:0] FMT_LSB16_MSB_OUT = 3'h5;
  localparam [2:0] FMT_LSB20_MSB_OUT = 3'h7;
  localparam [1:0] EMPH_44K1 = 2'h2;
  localparam [1:0] PWR_DAC_ONLY = 2'h1;
  localparam [1:0] PWR_BOTH = 2'h3;

  // Effective settings from static pins or serial registers
  // Reset values stand until the synchronised pins are valid
  always @(posedge clk_i) begin
    if (rst_i || !pins_ok) begin
      mode_o <= `CCSP_MODE_STATIC;
      sysclk_ratio_sel_o <= 2'h2;
      fmt_o <= 3'h4;
      offset_block_en_o <= 1'b0;
      atten_level_o <= 6'h00;
      low_boost_level_o <= 4'h0;
      high_boost_level_o <= 2'h0;
      emph_sel_o <= 2'h0;
      silence_en_o <= 1'b0;
      curve_o <= 2'h0;
      converter_power_sel_o <= 2'h3;
      gain_6db_o <= 1'b0;
    end else begin
      mode_o <= mode_s;
      if (serial_mode) begin
        sysclk_ratio_sel_o <= cfg_reg[5:4];
        fmt_o <= cfg_reg[3:1];
        offset_block_en_o <= cfg_reg[0];
        atten_level_o <= atten_reg;
        low_boost_level_o <= boost_reg[5:2];
        high_boost_level_o <= boost_reg[1:0];
        emph_sel_o <= emph_reg[4:3];
        silence_en_o <= emph_reg[2];
        curve_o <= emph_reg[1:0];
        converter_power_sel_o <= power_reg[1:0];
        gain_6db_o <= fmt_b_s;
      end else begin
        // Static mode; test mode reuses the static decode
        sysclk_ratio_sel_o <= pin_s[8] ? RATIO_384 : RATIO_256;
        case ({fmt_a_s, fmt_b_s})
          2'h0: fmt_o <= FMT_MSB;
          2'h1: fmt_o <= FMT_I2S;
          2'h2: fmt_o <= FMT_LSB20_MSB_OUT;
          default: fmt_o <= FMT_LSB16_MSB_OUT;
        endcase
        offset_block_en_o <= 1'b0;
        atten_level_o <= 6'h00;
        low_boost_level_o <= 4'h0;
        high_boost_level_o <= 2'h0;
        curve_o <= 2'h0;
        emph_sel_o <= (lvl3(emph_lvl_s) == `CCSP_LVL_MID) ?
                      EMPH_44K1 : 2'h0;
        silence_en_o <= (lvl3(emph_lvl_s) == `CCSP_LVL_HIGH);
        converter_power_sel_o <= (lvl3(gain_lvl_s) == `CCSP_LVL_LOW) ?
                                 PWR_DAC_ONLY : PWR_BOTH;
        gain_6db_o <= (lvl3(gain_lvl_s) == `CCSP_LVL_MID);
      end
    end
  end

  // Output hold after ADC power-up; restarts on each power-on edge
  wire adc_on = converter_power_sel_o[1];
  wire [13:0] hold_len = offset_block_en_o ?
                         14'd`CCSP_MUTE_FS_ON : 14'd`CCSP_MUTE_FS_OFF;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_adc_d_reg <= 1'b0;
      hold_cnt_reg <= 14'h0000;
      adc_serial_out_o <= 1'b0;
    end else begin
      pwr_adc_d_reg <= adc_on;
      if (!adc_on || (adc_on && !pwr_adc_d_reg))
        hold_cnt_reg <= 14'h0000;
      else if (sample_tick_i && hold_cnt_reg < hold_len)
        hold_cnt_reg <= hold_cnt_reg + 14'h0001;
      adc_serial_out_o <= (hold_cnt_reg >= hold_len) && adc_on &&
                          adc_filter_valid_i && adc_data_i;
    end
  end

  // Overload flag retriggerable hold; cleared outside serial mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      ovl_cnt_reg <= 10'h000;
      fmt_sel_a_or_overload_flag_o <= 1'b0;
    end else begin
      if (!serial_mode)
        ovl_cnt_reg <= 10'h000; // Old overloads must not leak into serial
      else if (overload_det_i)
        ovl_cnt_reg <= 10'd`CCSP_OVL_FS;
      else if (sample_tick_i && ovl_cnt_reg != 10'h000)
        ovl_cnt_reg <= ovl_cnt_reg - 10'h001;
      fmt_sel_a_or_overload_flag_o <= serial_mode &&
        (overload_det_i || ovl_cnt_reg != 10'h000);
    end
  end
endmodule
`default_nettype wire

// file: bench/ccsp_monitor.sv
// Port checker of the codec control block
`timescale 1ns/1ps
`default_nettype none
module ccsp_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_sel_a_i,
  input wire logic ctrl_sel_b_i,
  input wire logic clk_ratio_pin_or_shift_clock_i,
  input wire logic [1:0] gain_pwr_pin_or_serial_line_i,
  input wire logic fmt_sel_b_or_gain_pin_i,
  input wire logic sample_tick_i,
  input wire logic overload_det_i,
  input wire logic fmt_sel_a_or_overload_flag_o,
  input wire logic adc_serial_out_o,
  input wire logic [1:0] mode_o,
  input wire logic [1:0] sysclk_ratio_sel_o,
  input wire logic offset_block_en_o,
  input wire logic [5:0] atten_level_o,
  input wire logic [1:0] converter_power_sel_o,
  input wire logic gain_6db_o
);
  wire flag = fmt_sel_a_or_overload_flag_o;
  wire sck = clk_ratio_pin_or_shift_clock_i;
  wire [1:0] gp = gain_pwr_pin_or_serial_line_i;
  logic [13:0] ocnt;
  logic [13:0] hcnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Sample ticks since last overload and since ADC power-up; saturating
  always @(posedge clk_i) begin
    if (rst_i || overload_det_i) ocnt <= 14'h0000;
    else if (sample_tick_i && ocnt < 14'h3FFF) ocnt <= ocnt + 14'h0001;
    if (rst_i || $rose(converter_power_sel_o[1])) hcnt <= 14'h0000;
    else if (sample_tick_i && hcnt < 14'h3FFF) hcnt <= hcnt + 14'h0001;
  end
  // Pins held steady long enough to pass the synchroniser
  sequence s_st_ratio;
    (mode_o == 2'h3 && $stable(sck))[*4];
  endsequence
  sequence s_st_gain;
    (mode_o == 2'h3 && $stable(gp) && gp != 2'h0)[*4];
  endsequence
  sequence s_port_quiet;
    (mode_o == 2'h0 && $stable(sck))[*8];
  endsequence
  chk_mode_follow:
    assert property ($stable({ctrl_sel_b_i, ctrl_sel_a_i})[*4]
      |-> mode_o == {ctrl_sel_b_i, ctrl_sel_a_i}) else $error("mode wrong");
  chk_static_ratio:
    assert property (s_st_ratio |-> sysclk_ratio_sel_o == (sck ? 2'h1 : 2'h2))
      else $error("static ratio wrong");
  chk_static_gain:
    assert property (s_st_gain |-> gain_6db_o == (gp == 2'h1))
      else $error("static gain wrong");
  chk_serial_gain:
    assert property ((mode_o == 2'h0 && $stable(fmt_sel_b_or_gain_pin_i))[*4]
      |-> gain_6db_o == fmt_sel_b_or_gain_pin_i) else $error("gain wrong");
  chk_port_persist:
    assert property (s_port_quiet |-> $stable(atten_level_o))
      else $error("register changed without shift clock");
  chk_ovl_rise:
    assert property (mode_o == 2'h0 && overload_det_i |-> ##[1:2] flag)
      else $error("overload flag late");
  chk_ovl_hold:
    assert property ($fell(flag) && mode_o == 2'h0 && $past(mode_o) == 2'h0
      |-> ocnt >= 14'h0200) else $error("overload flag dropped early");
  chk_flag_off:
    assert property (mode_o != 2'h0 && $past(mode_o) != 2'h0 |-> !flag)
      else $error("overload flag outside serial mode");
  chk_dout_hold:
    assert property ($rose(adc_serial_out_o)
      |-> hcnt >= (offset_block_en_o ? 14'h3000 : 14'h0400))
      else $error("serial output released early");
endmodule
bind ccsp_top ccsp_monitor u_mon (.*);
`default_nettype wire

// file: bench/ccsp_host.sv
// Host model driving the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module ccsp_host (
  input wire logic clk_i,
  output logic sck_o,
  output logic phase_o,
  output logic sdat_o
);
  // Shift clock stands low between bytes
  initial begin
    sck_o = 1'b0;
    phase_o = 1'b1;
    sdat_o = 1'b0;
  end
  // One byte bit 0 first, 400 ns per bit; line flips after release
  task automatic xfer(input logic ph, input logic [7:0] b);
    phase_o = ph;
    for (int i = 0; i < 8; i++) begin
      sdat_o = b[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0;
    end
    sdat_o = ~sdat_o;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: bench/ccsp_top_bench.sv
// Self-checking bench of the codec control block
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_regs.vh"
module ccsp_top_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, ser = 1'b0;
  logic sa = 1'b1, sb = 1'b1, rp = 1'b0, fa = 1'b0, fb = 1'b0;
  logic tick = 1'b0, ovl = 1'b0, one = 1'b1;
  logic [1:0] em = 2'h0, gp = 2'h0;
  logic [2:0] ft [4] = '{3'h4, 3'h0, 3'h7, 3'h5};
  wire sck, ph, sd, flag, dout, dcen, sil, g6;
  wire [1:0] mode, ratio, hib, emph, curve, pwr;
  wire [2:0] fmt;
  wire [5:0] atten;
  wire [3:0] lowb;
  int n_fail = 0, checks = 0;
  ccsp_host h (.clk_i(clk_i), .sck_o(sck), .phase_o(ph), .sdat_o(sd));
  ccsp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ctrl_sel_a_i(sa),
    .ctrl_sel_b_i(sb), .clk_ratio_pin_or_shift_clock_i(ser ? sck : rp),
    .emph_mute_pin_or_phase_line_i(ser ? {ph, 1'b0} : em),
    .gain_pwr_pin_or_serial_line_i(ser ? {sd, 1'b0} : gp),
    .fmt_sel_b_or_gain_pin_i(fb), .fmt_sel_a_i(fa), .sample_tick_i(tick),
    .overload_det_i(ovl), .adc_filter_valid_i(one), .adc_data_i(one),
    .fmt_sel_a_or_overload_flag_o(flag), .adc_serial_out_o(dout),
    .mode_o(mode), .sysclk_ratio_sel_o(ratio), .fmt_o(fmt),
    .offset_block_en_o(dcen), .atten_level_o(atten),
    .low_boost_level_o(lowb), .high_boost_level_o(hib), .emph_sel_o(emph),
    .silence_en_o(sil), .curve_o(curve), .converter_power_sel_o(pwr),
    .gain_6db_o(g6));
  always #25 clk_i = ~clk_i;
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Sample period pulses, one clock high out of two
  task automatic tk(input int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well past the whole sequence
  initial begin
    #3000000;
    n_fail++;
    end_sim();
  end
  // Static decode, mode pins, then the serial port
  initial begin
    cyc(16);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rp = i[0];
      em = 2'(i % 3);
      gp = 2'(i % 3);
      {fa, fb} = 2'(i);
      cyc(6);
      ck(8'(ratio), rp ? 8'h01 : 8'h02);
      ck(8'({emph, sil}), 8'(em == 2'h1 ? 3'h4 : {2'h0, em == 2'h2}));
      ck(8'(gp == 2'h0 ? pwr : {1'b0, g6}), 8'(gp != 2'h2));
      ck(8'(fmt), 8'(ft[i]));
    end
    ovl = 1'b1;
    cyc(3);
    ck(8'(flag), 8'h00);
    ovl = 1'b0;
    ser = 1'b1;
    for (int m = 3; m >= 0; m -= 2) begin
      {sb, sa} = 2'(m);
      cyc(6);
      ck(8'(mode), 8'(m));
    end
    {sb, sa} = `CCSP_MODE_SERIAL;
    cyc(6);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, `CCSP_TYPE_DATA});
    h.xfer(1'b1, 8'h3F);
    h.xfer(1'b1, 8'h5B);
    h.xfer(1'b1, 8'h9E);
    h.xfer(1'b1, 8'hC2);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, `CCSP_TYPE_STATUS});
    h.xfer(1'b1, 8'h16);
    cyc(6);
    ck(8'(atten), 8'h3F);
    ck(8'({lowb, hib}), 8'h1B);
    ck(8'({emph, sil, curve}), 8'h1E);
    ck(8'({ratio, fmt, dcen}), 8'h16);
    h.xfer(1'b0, {6'h15, 2'h0});
    h.xfer(1'b1, 8'h05);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, 2'h1});
    h.xfer(1'b1, 8'h06);
    cyc(6);
    ck(8'(atten), 8'h3F);
    for (int i = 1; i >= 0; i--) begin
      fb = i[0];
      cyc(6);
      ck(8'(g6), 8'(i));
    end
    ovl = 1'b1;
    cyc(1);
    ovl = 1'b0;
    cyc(3);
    ck(8'(flag), 8'h01);
    tk(511);
    ck(8'(flag), 8'h01);
    tk(20);
    ck(8'(flag), 8'h00);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, `CCSP_TYPE_DATA});
    h.xfer(1'b1, 8'hC1);
    h.xfer(1'b1, 8'hC3);
    cyc(4);
    ck(8'(pwr), 8'h03);
    tk(1000);
    ck(8'(dout), 8'h00);
    tk(40);
    ck(8'(dout), 8'h01);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, `CCSP_TYPE_STATUS});
    h.xfer(1'b1, 8'h17);
    h.xfer(1'b0, {`CCSP_OWN_ADDR, `CCSP_TYPE_DATA});
    h.xfer(1'b1, 8'hC1);
    h.xfer(1'b1, 8'hC3);
    cyc(4);
    ck(8'({ratio, fmt, dcen}), 8'h17);
    tk(12280);
    ck(8'(dout), 8'h00);
    tk(40);
    ck(8'(dout), 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
